/* design/lcd_cmd_pkg.sv */
// Constants, encodings and reset values shared by the LCD command decoder files.
package lcd_cmd_pkg;

   // Display RAM geometry.
   localparam int PAGES       = 4;
   localparam int COLUMNS     = 80;
   localparam logic [6:0] COL_LIMIT = 7'h50;

   // Command codes compared against the full byte or its upper bits.
   localparam logic [6:0] OP_DISP_HI   = 7'h57;
   localparam logic [6:0] OP_ADC_HI    = 7'h50;
   localparam logic [6:0] OP_STATIC_HI = 7'h52;
   localparam logic [6:0] OP_DUTY_HI   = 7'h54;
   localparam logic [2:0] OP_START_HI  = 3'h6;
   localparam logic [5:0] OP_PAGE_HI   = 6'h2e;
   localparam logic [7:0] OP_RMW       = 8'he0;
   localparam logic [7:0] OP_END       = 8'hee;
   localparam logic [7:0] OP_RESET     = 8'he2;

   // Status byte field positions.
   localparam int ST_BUSY_BIT  = 7;
   localparam int ST_ORDER_BIT = 6;
   localparam int ST_OFF_BIT   = 5;
   localparam int ST_RST_BIT   = 4;

   // Values after the hardware reset.
   localparam logic       RST_DISP_ON  = 1'b0;
   localparam logic [4:0] RST_START    = 5'h00;
   localparam logic [1:0] RST_PAGE     = 2'h3;
   localparam logic [6:0] RST_COL      = 7'h00;
   localparam logic       RST_REVERSED = 1'b0;
   localparam logic       RST_STATIC   = 1'b0;
   localparam logic       RST_DUTY32   = 1'b1;
   localparam logic       RST_RMW      = 1'b0;

   // Values loaded by the soft reset command.
   localparam logic [4:0] SOFT_START = 5'h00;
   localparam logic [1:0] SOFT_PAGE  = 2'h0;
   localparam logic [6:0] SOFT_COL   = 7'h00;

   // Internal initialisation time and its cycle count at the 40 MHz clock.
   localparam int CLK_MHZ       = 40;
   localparam int INIT_TIME_NS  = 1000;
   localparam int INIT_CYCLES   = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;

   // Decoded command kinds.
   typedef enum logic [3:0] {
      CMD_NONE, CMD_DISP, CMD_START, CMD_PAGE, CMD_COL, CMD_ADC,
      CMD_STATIC, CMD_DUTY, CMD_RMW, CMD_END, CMD_RESET
   } cmd_t;

endpackage : lcd_cmd_pkg

/* design/two_entry_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module two_entry_buffer #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // Filling side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side.
   input  wire logic             out_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data
);

   // Whole state of the buffer: two slots and a fill count.
   typedef struct packed {
      logic [1:0][WIDTH-1:0] slot;  // Slot 0 is the head.
      logic [1:0]            count; // Number of held words, 0 to 2.
   } buf_t;

   buf_t q;  // Registered state.
   buf_t d;  // Next state.
   logic push;  // Word enters this cycle.
   logic pop;   // Word leaves this cycle.

   // Ready and valid come straight from the count, so full and empty are exact.
   assign in_ready  = (q.count != 2'd2);
   assign out_valid = (q.count != 2'd0);
   assign out_data  = q.slot[0];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Shift on pop, then place the new word behind what remains.
   always_comb begin
      d = q;
      if (pop) begin
         d.slot[0] = q.slot[1];
      end
      if (push) begin
         // A push into a full buffer cannot happen, so the slot index stays in range.
         if ((q.count == 2'd0) || ((q.count == 2'd1) && pop)) begin
            d.slot[0] = in_data;
         end else begin
            d.slot[1] = in_data;
         end
      end
      d.count = q.count + {1'b0, push} - {1'b0, pop};
   end

   // Register the state; contents are cleared so outputs are defined at reset.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : two_entry_buffer

/* design/lcd_cmd_decoder.sv */
// Command decoder, display RAM and mode state of the LCD segment driver.
`timescale 1ns/1ps
module lcd_cmd_decoder #(
   parameter int PAGES   = lcd_cmd_pkg::PAGES,
   parameter int COLUMNS = lcd_cmd_pkg::COLUMNS
) (
   // Clock and synchronous active-low reset (the hardware init pin).
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // Host access request.
   input  wire logic       bus_valid,
   output logic            bus_ready,
   input  wire logic       cmd_data_select,
   input  wire logic       bus_read,
   input  wire logic [7:0] bus_wdata,
   // Read answers, through the two-entry buffer.
   output logic            rd_valid,
   input  wire logic       rd_ready,
   output logic [7:0]      rd_data,
   // Mode outputs towards the display timing and driver logic.
   output logic            display_on,
   output logic [4:0]      start_line,
   output logic            reversed_mapping,
   output logic            static_drive,
   output logic            duty_32,
   output logic            busy,
   // Power-save indications.
   output logic            power_save,
   output logic            lcd_drive_enable,
   output logic            seg_com_at_vdd,
   output logic            osc_enable,
   output logic            oscillator_node_oe,
   output logic            divider_cut
);

   // Host accesses in brief.
   // Taken when valid meets ready.
   // Back-to-back access needs no gap.
   // Reads answer a cycle later.
   // Writes show effect a cycle later.
   // Ready drops only with two answers.
   // A stalled reader stalls writes too.
   // That keeps the stream in order.

   // Busy time.
   // Both resets load one busy count.
   // Status reads are served meanwhile.
   // Other accesses are dropped.
   // A dropped data read answers zero.
   // So no answer is ever missing.

   // Data reads.
   // A read hands over the latch first.
   // The latch then takes the RAM byte.
   // So the first read is a dummy.
   // Reads never alter the RAM.
   // The column stops at its limit.
   // Beyond it nothing is stored.
   // Reads there load zero.

   // Read-modify-write.
   // Entry saves the column.
   // Only writes move the column.
   // The end command restores it.

   // Power save.
   // It is decoded from two mode bits.
   // It starts and ends with them.
   // It touches no register or byte.

   // Display RAM.
   // No reset clears it.
   // Unwritten bytes read unknown.
   localparam int BUSY_W = 8;  // Wide enough for the initialisation count.
   localparam int RAM_W  = $clog2(PAGES * COLUMNS);
   localparam logic [BUSY_W-1:0] INIT_CNT = BUSY_W'(lcd_cmd_pkg::INIT_CYCLES);

   // All control state of the decoder.
   typedef struct packed {
      logic              disp_on;    // Display switched on.
      logic [4:0]        start_line; // RAM line shown on the first common row.
      logic [1:0]        page;       // Page for host access.
      logic [6:0]        col;        // Column address counter.
      logic              reversed;   // Segment order is reversed.
      logic              static_on;  // Static drive enabled.
      logic              duty32;     // 1/32 duty selected.
      logic              rmw;        // Read-modify-write mode active.
      logic [6:0]        rmw_col;    // Column saved at read-modify-write entry.
      logic [7:0]        latch;      // Read output latch.
      logic [BUSY_W-1:0] busy_cnt;   // Remaining cycles of internal operation.
      logic              resetting;  // Initialisation in progress.
   } ctl_t;

   // State after the hardware reset; initialisation runs and the device is busy meanwhile.
   localparam ctl_t CTL_INIT = '{
      disp_on:    lcd_cmd_pkg::RST_DISP_ON,
      start_line: lcd_cmd_pkg::RST_START,
      page:       lcd_cmd_pkg::RST_PAGE,
      col:        lcd_cmd_pkg::RST_COL,
      reversed:   lcd_cmd_pkg::RST_REVERSED,
      static_on:  lcd_cmd_pkg::RST_STATIC,
      duty32:     lcd_cmd_pkg::RST_DUTY32,
      rmw:        lcd_cmd_pkg::RST_RMW,
      rmw_col:    lcd_cmd_pkg::RST_COL,
      latch:      8'h00,
      busy_cnt:   INIT_CNT,
      resetting:  1'b1
   };

   ctl_t q;  // Registered state.
   ctl_t d;  // Next state.

   // Display RAM, one byte per page and column; it is never cleared, not even by reset.
   logic [7:0] ram [0:PAGES*COLUMNS-1];

   logic             acc;        // Access taken this cycle.
   logic             push_valid; // Answer word enters the buffer.
   logic             push_ready; // Buffer has room.
   logic [7:0]       push_data;  // Answer word.
   logic             ram_we;     // Display RAM write strobe.
   logic [RAM_W-1:0] ram_addr;   // Current page and column as a RAM index.
   logic             col_ok;     // Column points inside the RAM.
   logic [7:0]       status;     // Status byte.

   // Flattens page and column into a RAM index.
   function automatic logic [RAM_W-1:0] ram_index(input logic [1:0] pg, input logic [6:0] cl);
      ram_index = RAM_W'(pg * COLUMNS + cl);
   endfunction : ram_index

   // Advances the column but holds it at the limit; higher addresses are invalid.
   function automatic logic [6:0] col_step(input logic [6:0] cl);
      col_step = (cl < lcd_cmd_pkg::COL_LIMIT) ? cl + 7'd1 : cl;
   endfunction : col_step

   // Maps a command byte to its kind; unknown codes give no command.
   function automatic lcd_cmd_pkg::cmd_t cmd_decode(input logic [7:0] b);
      if (b[7] == 1'b0) begin
         // Bit 7 low sets the column.
         cmd_decode = lcd_cmd_pkg::CMD_COL;
      end else if (b[7:5] == lcd_cmd_pkg::OP_START_HI) begin
         // Start line, five bits.
         cmd_decode = lcd_cmd_pkg::CMD_START;
      end else if (b[7:1] == lcd_cmd_pkg::OP_DISP_HI) begin
         // Display on or off.
         cmd_decode = lcd_cmd_pkg::CMD_DISP;
      end else if (b[7:2] == lcd_cmd_pkg::OP_PAGE_HI) begin
         // Page, two bits.
         cmd_decode = lcd_cmd_pkg::CMD_PAGE;
      end else if (b[7:1] == lcd_cmd_pkg::OP_ADC_HI) begin
         // Segment order.
         cmd_decode = lcd_cmd_pkg::CMD_ADC;
      end else if (b[7:1] == lcd_cmd_pkg::OP_STATIC_HI) begin
         // Static drive.
         cmd_decode = lcd_cmd_pkg::CMD_STATIC;
      end else if (b[7:1] == lcd_cmd_pkg::OP_DUTY_HI) begin
         // Duty selection.
         cmd_decode = lcd_cmd_pkg::CMD_DUTY;
      end else if (b == lcd_cmd_pkg::OP_RMW) begin
         // Read-modify-write entry.
         cmd_decode = lcd_cmd_pkg::CMD_RMW;
      end else if (b == lcd_cmd_pkg::OP_END) begin
         // Read-modify-write end.
         cmd_decode = lcd_cmd_pkg::CMD_END;
      end else if (b == lcd_cmd_pkg::OP_RESET) begin
         // Soft reset.
         cmd_decode = lcd_cmd_pkg::CMD_RESET;
      end else begin
         // No defined code matches.
         cmd_decode = lcd_cmd_pkg::CMD_NONE;
      end
   endfunction : cmd_decode

   // Every access waits for buffer room; this keeps the host in step with a stalled reader.
   assign bus_ready  = push_ready;
   assign acc        = bus_valid & bus_ready;
   assign push_valid = acc & bus_read;
   assign busy       = (q.busy_cnt != '0);
   assign col_ok     = (q.col < lcd_cmd_pkg::COL_LIMIT);
   assign ram_addr   = ram_index(q.page, q.col);

   // Status byte: order flag reads 1 for forward, on/off flag reads 1 for off.
   // Reading status changes no state.
   always_comb begin
      status = 8'h00;
      status[lcd_cmd_pkg::ST_BUSY_BIT]  = busy;
      status[lcd_cmd_pkg::ST_ORDER_BIT] = ~q.reversed;
      status[lcd_cmd_pkg::ST_OFF_BIT]   = ~q.disp_on;
      status[lcd_cmd_pkg::ST_RST_BIT]   = q.resetting;
   end

   // Next-state logic: internal timing, then the one access of this cycle.
   always_comb begin
      d         = q;
      ram_we    = 1'b0;
      push_data = 8'h00;
      // The internal operation counts down; the resetting flag drops with it.
      if (busy) begin
         d.busy_cnt = q.busy_cnt - BUSY_W'(1);
         if (q.busy_cnt == BUSY_W'(1)) begin
            d.resetting = 1'b0;
         end
      end
      // At most one access per cycle.
      if (acc) begin
         if (!cmd_data_select && bus_read) begin
            // A status read is answered even while busy.
            push_data = status;
         end else if (busy) begin
            // Everything else is rejected while busy; a rejected read answers zero.
            push_data = 8'h00;
         end else if (cmd_data_select && !bus_read) begin
            // Data write; an out-of-range column stores nothing.
            ram_we = col_ok;
            d.col  = col_step(q.col);
         end else if (cmd_data_select && bus_read) begin
            // The host gets the old latch; the latch then takes the addressed byte.
            push_data = q.latch;
            d.latch   = col_ok ? ram[ram_addr] : 8'h00;
            if (!q.rmw) begin
               d.col = col_step(q.col);
            end
         end else begin
            case (cmd_decode(bus_wdata))
               // Display on or off.
               lcd_cmd_pkg::CMD_DISP: begin
                  d.disp_on = bus_wdata[0];
               end

               // First shown RAM line.
               lcd_cmd_pkg::CMD_START: begin
                  d.start_line = bus_wdata[4:0];
               end

               // Page for host access.
               lcd_cmd_pkg::CMD_PAGE: begin
                  d.page = bus_wdata[1:0];
               end

               // Column for host access.
               lcd_cmd_pkg::CMD_COL: begin
                  d.col = bus_wdata[6:0];
               end

               // Segment order.
               lcd_cmd_pkg::CMD_ADC: begin
                  d.reversed = bus_wdata[0];
               end

               // Static drive on or off.
               lcd_cmd_pkg::CMD_STATIC: begin
                  d.static_on = bus_wdata[0];
               end

               // Duty selection.
               lcd_cmd_pkg::CMD_DUTY: begin
                  d.duty32 = bus_wdata[0];
               end

               lcd_cmd_pkg::CMD_RMW: begin
                  // The column is saved so that the end command can return to it.
                  d.rmw     = 1'b1;
                  d.rmw_col = q.col;
               end

               lcd_cmd_pkg::CMD_END: begin
                  // Ending outside the mode is harmless: the saved column is then stale,
                  // so it is restored only when the mode is really active.
                  d.rmw = 1'b0;
                  if (q.rmw) begin
                     d.col = q.rmw_col;
                  end
               end

               lcd_cmd_pkg::CMD_RESET: begin
                  // Soft reset touches the start line, addresses, the busy count and the resetting flag only; RAM and other modes stay.
                  d.start_line = lcd_cmd_pkg::SOFT_START;
                  d.col        = lcd_cmd_pkg::SOFT_COL;
                  d.page       = lcd_cmd_pkg::SOFT_PAGE;
                  d.busy_cnt   = INIT_CNT;
                  d.resetting  = 1'b1;
               end

               // Unknown bytes change nothing.
               default: begin
                  d = d;
               end
            endcase
         end
      end
   end

   // Control state register; the hardware reset is the only full initialisation.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= CTL_INIT;
      end else begin
         q <= d;
      end
   end

   // Display RAM write port; power save does not touch the array.
   // Out-of-range columns never raise the strobe.
   always_ff @(posedge ref_clk) begin
      if (ram_we) begin
         ram[ram_addr] <= bus_wdata;
      end
   end

   // Answer buffer, so a stalled reader loses no word.
   // Two entries let reads stream at full rate.
   two_entry_buffer #(
      .WIDTH (8)
   ) u_answer_buf (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_ready (rd_ready),
      .out_valid (rd_valid),
      .out_data  (rd_data)
   );

   // Mode outputs straight from the state flops.
   // They stay glitch free for the display timing logic.
   assign display_on       = q.disp_on;
   assign start_line       = q.start_line;
   assign reversed_mapping = q.reversed;
   assign static_drive     = q.static_on;
   assign duty_32          = q.duty32;

   // Power save follows the two mode bits at once, so it ends as soon as either changes.
   // The gated drive and bias parts sit outside this block.
   // Here they only see the enables below.
   assign power_save         = q.static_on & ~q.disp_on;
   assign lcd_drive_enable   = ~power_save;
   assign seg_com_at_vdd     = power_save;
   assign osc_enable         = ~power_save;
   assign oscillator_node_oe = ~power_save;
   assign divider_cut        = power_save;

endmodule : lcd_cmd_decoder

/* tb/lcd_cmd_decoder_sva.sv */
// Concurrent checks on the ports of the LCD command decoder.
`timescale 1ns/1ps
module lcd_cmd_decoder_sva (
   // Clock and reset.
   input wire logic       ref_clk,
   input wire logic       rst_b,
   // Host access and answer stream.
   input wire logic       bus_valid,
   input wire logic       bus_ready,
   input wire logic       cmd_data_select,
   input wire logic       bus_read,
   input wire logic [7:0] bus_wdata,
   input wire logic       rd_valid,
   input wire logic       rd_ready,
   input wire logic [7:0] rd_data,
   // Mode and power-save levels.
   input wire logic       display_on,
   input wire logic [4:0] start_line,
   input wire logic       reversed_mapping,
   input wire logic       static_drive,
   input wire logic       duty_32,
   input wire logic       busy,
   input wire logic       power_save,
   input wire logic       lcd_drive_enable,
   input wire logic       seg_com_at_vdd,
   input wire logic       osc_enable,
   input wire logic       oscillator_node_oe,
   input wire logic       divider_cut
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // A command write taken while the decoder is idle.
   sequence s_cmd;
      bus_valid && bus_ready && !cmd_data_select && !bus_read && !busy;
   endsequence
   // A command write taken while an internal operation still runs.
   sequence s_cmd_busy;
      bus_valid && bus_ready && !cmd_data_select && !bus_read && busy;
   endsequence
   a_display_cmd: assert property (s_cmd ##0 (bus_wdata[7:1] == 7'h57) |=> display_on == $past(bus_wdata[0]))
      else $error("display on/off command not applied");
   a_start_cmd: assert property (s_cmd ##0 (bus_wdata[7:5] == 3'h6) |=> start_line == $past(bus_wdata[4:0]))
      else $error("start line command not applied");
   a_order_cmd: assert property (s_cmd ##0 (bus_wdata[7:1] == 7'h50) |=> reversed_mapping == $past(bus_wdata[0]))
      else $error("segment order command not applied");
   a_static_cmd: assert property (s_cmd ##0 (bus_wdata[7:1] == 7'h52) |=> static_drive == $past(bus_wdata[0]))
      else $error("static drive command not applied");
   a_duty_cmd: assert property (s_cmd ##0 (bus_wdata[7:1] == 7'h54) |=> duty_32 == $past(bus_wdata[0]))
      else $error("duty command not applied");
   // Commands arriving during an internal operation must leave every mode level alone.
   a_busy_reject: assert property (s_cmd_busy |=> $stable(display_on) && $stable(start_line)
      && $stable(reversed_mapping) && $stable(static_drive) && $stable(duty_32))
      else $error("command acted on while busy");
   // A stalled answer must neither vanish nor change.
   a_answer_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("answer lost during stall");
   a_save_entry: assert property (power_save == (static_drive && !display_on))
      else $error("power save state wrong");
   a_save_drive: assert property (power_save |-> seg_com_at_vdd && !lcd_drive_enable)
      else $error("drive not stopped in power save");
   a_save_osc: assert property (power_save == (!osc_enable && !oscillator_node_oe))
      else $error("oscillator not stopped in power save");
   a_save_divider: assert property (divider_cut == power_save)
      else $error("divider cut not following power save");
endmodule : lcd_cmd_decoder_sva

bind lcd_cmd_decoder lcd_cmd_decoder_sva u_sva (
   .ref_clk(ref_clk), .rst_b(rst_b), .bus_valid(bus_valid), .bus_ready(bus_ready),
   .cmd_data_select(cmd_data_select), .bus_read(bus_read), .bus_wdata(bus_wdata), .rd_valid(rd_valid),
   .rd_ready(rd_ready), .rd_data(rd_data), .display_on(display_on), .start_line(start_line),
   .reversed_mapping(reversed_mapping), .static_drive(static_drive), .duty_32(duty_32), .busy(busy),
   .power_save(power_save), .lcd_drive_enable(lcd_drive_enable), .seg_com_at_vdd(seg_com_at_vdd),
   .osc_enable(osc_enable), .oscillator_node_oe(oscillator_node_oe), .divider_cut(divider_cut));

/* tb/host_reader.sv */
// Host-side reader that drains the decoder's answer buffer and can stall it.
`timescale 1ns/1ps
module host_reader (
   // Clock and reset.
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // Stall request from the bench.
   input  wire logic       stall,
   // Answer stream from the decoder.
   input  wire logic       rd_valid,
   output logic            rd_ready,
   input  wire logic [7:0] rd_data
);
   logic [7:0] got [$];  // Words taken, oldest first.
   initial rd_ready = 1'b0;
   // Ready follows the stall request one edge late, as a slow host would.
   always @(posedge ref_clk) begin
      rd_ready <= rst_b && !stall;
      // A word counts as taken only where valid and ready both stand at the edge.
      if (rst_b && rd_valid && rd_ready) begin
         got.push_back(rd_data);
      end
   end
endmodule : host_reader

/* tb/lcd_cmd_decoder_tb.sv */
// Self-checking bench for the LCD command decoder.
`timescale 1ns/1ps
module lcd_cmd_decoder_tb;
   logic       ref_clk = 1'b0;  // 40 MHz clock.
   logic       rst_b = 1'b0;    // Synchronous reset, active low.
   logic       bus_valid = 1'b0, cmd_data_select = 1'b0, bus_read = 1'b0, stall = 1'b0;
   logic [7:0] bus_wdata = 8'h00;
   logic       bus_ready, rd_valid, rd_ready, display_on, reversed_mapping, static_drive, duty_32, busy;
   logic       power_save, lcd_drive_enable, seg_com_at_vdd, osc_enable, oscillator_node_oe, divider_cut;
   logic [7:0] rd_data, w;
   logic [4:0] start_line;
   int         fails = 0;
   int         samples_checked = 0;

   lcd_cmd_decoder dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .bus_valid(bus_valid), .bus_ready(bus_ready),
      .cmd_data_select(cmd_data_select), .bus_read(bus_read), .bus_wdata(bus_wdata), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .display_on(display_on), .start_line(start_line),
      .reversed_mapping(reversed_mapping), .static_drive(static_drive), .duty_32(duty_32), .busy(busy),
      .power_save(power_save), .lcd_drive_enable(lcd_drive_enable), .seg_com_at_vdd(seg_com_at_vdd),
      .osc_enable(osc_enable), .oscillator_node_oe(oscillator_node_oe), .divider_cut(divider_cut));
   host_reader hp (.ref_clk(ref_clk), .rst_b(rst_b), .stall(stall), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data));

   always #12.5 ref_clk = ~ref_clk;

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // A wait that ran out counts as a mismatch and closes the run.
   task automatic timed_out();
      fails++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      finish_test();
   endtask : timed_out

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   // Presents one access and holds it up to the edge that takes it; valid stays high.
   task automatic acc(input logic cds, input logic rd, input logic [7:0] d);
      int n;
      n = 0;
      bus_valid = 1'b1;
      cmd_data_select = cds;
      bus_read = rd;
      bus_wdata = d;
      while (bus_ready !== 1'b1) begin
         n++;
         if (n > 40) timed_out();
         @(posedge ref_clk) #2;
      end
      @(posedge ref_clk) #2;
   endtask : acc

   task automatic cmd(input logic [7:0] d); acc(1'b0, 1'b0, d); endtask : cmd
   task automatic wr(input logic [7:0] d); acc(1'b1, 1'b0, d); endtask : wr
   task automatic rd(); acc(1'b1, 1'b1, 8'h00); endtask : rd
   task automatic st(); acc(1'b0, 1'b1, 8'h00); endtask : st

   // Drops the request and lets one edge pass, so no signal is driven twice in a step.
   task automatic idle();
      bus_valid = 1'b0;
      @(posedge ref_clk) #2;
   endtask : idle

   // Takes the oldest answer the reader collected, waiting a bounded time.
   task automatic take(output logic [7:0] v);
      int n;
      n = 0;
      do begin
         idle();
         n++;
         if (n > 40) timed_out();
      end while (hp.got.size() == 0);
      v = hp.got.pop_front();
   endtask : take

   task automatic pop(input logic [7:0] exp);
      logic [7:0] v;
      take(v);
      check(v, exp);
   endtask : pop

   // Waits, bounded, for the internal operation to end.
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         idle();
         n++;
         if (n > 60) timed_out();
      end while (busy !== 1'b0);
   endtask : wait_idle

   initial begin
      repeat (3) @(posedge ref_clk);
      #2;
      rst_b = 1'b1;
      check({busy, display_on, duty_32, static_drive, reversed_mapping, 3'h0}, 8'ha0);
      st();
      pop(8'hf0);
      wait_idle();
      st();
      pop(8'h60);
      // Mode commands back to back, two undefined bytes among them.
      cmd(8'haf);
      cmd(8'ha1);
      cmd(8'ha5);
      cmd(8'ha8);
      cmd(8'hc5);
      cmd(8'he5);
      cmd(8'hfb);
      idle();
      check({display_on, reversed_mapping, static_drive, duty_32, 4'h0}, 8'he0);
      check({3'h0, start_line}, 8'h05);
      st();
      pop(8'h00);
      // Power save entered by display off, then left both ways.
      cmd(8'hae);
      idle();
      check({power_save, lcd_drive_enable, seg_com_at_vdd, osc_enable, oscillator_node_oe, divider_cut, 2'h0}, 8'ha4);
      check({1'h0, start_line, reversed_mapping, duty_32}, 8'h16);
      cmd(8'haf);
      idle();
      check({power_save, lcd_drive_enable, seg_com_at_vdd, osc_enable, oscillator_node_oe, divider_cut, 2'h0}, 8'h58);
      cmd(8'hae);
      cmd(8'ha4);
      cmd(8'ha0);
      cmd(8'ha9);
      idle();
      check({power_save, reversed_mapping, duty_32, 5'h0}, 8'h20);
      // Page separation and the column stopping at its limit.
      cmd(8'hba);
      cmd(8'h4e);
      wr(8'h11);
      wr(8'h22);
      wr(8'h33);
      cmd(8'hb9);
      cmd(8'h4e);
      wr(8'h44);
      cmd(8'hba);
      cmd(8'h4e);
      rd();
      rd();
      rd();
      rd();
      take(w);
      pop(8'h11);
      pop(8'h22);
      pop(8'h00);
      // Read-modify-write: reads hold the column, end restores it.
      cmd(8'hb8);
      cmd(8'h0a);
      wr(8'h5a);
      cmd(8'h0a);
      cmd(8'he0);
      rd();
      rd();
      wr(8'ha5);
      wr(8'h3c);
      cmd(8'hee);
      rd();
      rd();
      rd();
      take(w);
      pop(8'h5a);
      take(w);
      pop(8'ha5);
      pop(8'h3c);
      // Soft reset, with a command refused while it runs.
      cmd(8'hb8);
      cmd(8'h00);
      wr(8'h81);
      cmd(8'hba);
      cmd(8'h05);
      cmd(8'haf);
      cmd(8'he2);
      cmd(8'hae);
      st();
      pop(8'hd0);
      wait_idle();
      check({start_line, display_on, 2'h0}, 8'h04);
      rd();
      rd();
      take(w);
      pop(8'h81);
      // Answer buffer filled while the reader stalls, then drained.
      stall = 1'b1;
      idle();
      idle();
      st();
      st();
      check({7'h0, bus_ready}, 8'h00);
      bus_valid = 1'b0;
      stall = 1'b0;
      pop(8'h40);
      pop(8'h40);
      finish_test();
   end
endmodule : lcd_cmd_decoder_tb
